// file: core/drs_core.sv
// dedicated cpu register set with flag logic and apb access
//
// Contract
// - 16-bit program counter holds fetch location
// - 16-bit accumulator; byte ops use lower byte
// - 16-bit temporary accumulator second operand
// - 16-bit index register modifies operand addresses
// - 16-bit extra pointer holds memory address
// - 16-bit stack pointer addresses stack
// - status word: bank pointer high, flags low
// - half carry from bit 3 to 4
// - interrupt enable gates; cleared on reset
// - service only levels above current level
// - negative flag follows result msb
// - zero flag set on zero result
// - overflow flag on two's complement overflow
// - carry out of bit 7, shift-out; wide ops here take carry out of bit 15
// - banks of eight 8-bit registers
// - 16 or 32 banks by ram size
//
// Chosen here: the register addresses and register access over APB.
module drs_core
    import drs_pkg::*;
#(
    parameter int BANKS = 32
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // datapath strobes from the execution unit
    input  wire logic        pc_load,
    input  wire logic        pc_inc,
    input  wire logic [15:0] pc_value,
    input  wire logic        acc_load,
    input  wire logic        tmp_load,
    input  wire logic        idx_load,
    input  wire logic        exp_load,
    input  wire logic        stk_load,
    input  wire logic [15:0] load_value,
    // alu result and flag update
    input  wire logic [2:0]  alu_op,
    input  wire logic        alu_wide,
    input  wire logic        alu_shift_bit,
    input  wire logic [7:0]  alu_logic_res,
    // interrupt qualification and register address
    input  wire logic        irq_req,
    input  wire logic [1:0]  irq_level,
    input  wire logic [2:0]  gpr_num,
    // register outputs
    output logic      [15:0] program_counter,
    output logic      [15:0] main_accumulator,
    output logic      [15:0] temp_accumulator,
    output logic      [15:0] index_register,
    output logic      [15:0] extra_pointer,
    output logic      [15:0] stack_pointer,
    output logic      [15:0] program_status_word,
    output logic             irq_accept,
    output logic      [15:0] gpr_addr
);

    localparam int BW = $clog2(BANKS);

    // all module state
    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] acc;
        logic [15:0] tmp;
        logic [15:0] idx;
        logic [15:0] exp;
        logic [15:0] stk;
        logic [7:0]  bank_pointer;
        logic [7:0]  condition_flags;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        accept;
        logic [15:0] gaddr;
    } drs_state_s;

    drs_state_s st_r;
    drs_state_s st_nxt;

    logic [8:0]  sum9;
    logic [4:0]  sum5;
    logic [16:0] sum17;
    logic [7:0]  res8;
    logic [15:0] res16;
    logic        wr_acc;
    logic        rd_acc;
    logic [15:0] bank_sel;

    always_comb begin
        st_nxt = st_r;
        sum9   = 9'h000;
        sum5   = 5'h00;
        sum17  = 17'h00000;
        res8   = 8'h00;
        res16  = 16'h0000;
        bank_sel = 16'h0000;
        wr_acc = psel && penable && pwrite;
        rd_acc = psel && penable && !pwrite;
        st_st_defaults();
        // datapath loads
        if (pc_load) begin
            st_nxt.pc = pc_value;
        end else if (pc_inc) begin
            st_nxt.pc = st_r.pc + 16'h0001;
        end
        if (acc_load) st_nxt.acc = load_value;
        if (tmp_load) st_nxt.tmp = load_value;
        if (idx_load) st_nxt.idx = load_value;
        if (exp_load) st_nxt.exp = load_value;
        if (stk_load) st_nxt.stk = load_value;
        // alu on acc and tmp; byte ops touch low byte only
        case (drs_op_e'(alu_op))
            DRS_OP_ADD, DRS_OP_SUB: begin
                if (alu_op == DRS_OP_SUB) begin
                    sum5  = {1'b0, st_r.acc[3:0]} - {1'b0, st_r.tmp[3:0]};
                    sum9  = {1'b0, st_r.acc[7:0]} - {1'b0, st_r.tmp[7:0]};
                    sum17 = {1'b0, st_r.acc} - {1'b0, st_r.tmp};
                end else begin
                    sum5  = {1'b0, st_r.acc[3:0]} + {1'b0, st_r.tmp[3:0]};
                    sum9  = {1'b0, st_r.acc[7:0]} + {1'b0, st_r.tmp[7:0]};
                    sum17 = {1'b0, st_r.acc} + {1'b0, st_r.tmp};
                end
                st_nxt.condition_flags[DRS_CF_H] = sum5[4];
                if (alu_wide) begin
                    res16 = sum17[15:0];
                    st_nxt.acc = res16;
                    st_nxt.condition_flags[DRS_CF_N] = res16[15];
                    st_nxt.condition_flags[DRS_CF_Z] =
                        (res16 == 16'h0000);
                    st_nxt.condition_flags[DRS_CF_V] =
                        (alu_op == DRS_OP_SUB)
                        ? (st_r.acc[15] != st_r.tmp[15])
                          && (res16[15] != st_r.acc[15])
                        : (st_r.acc[15] == st_r.tmp[15])
                          && (res16[15] != st_r.acc[15]);
                    st_nxt.condition_flags[DRS_CF_C] = sum17[16];
                end else begin
                    res8 = sum9[7:0];
                    st_nxt.acc[7:0] = res8;
                    st_nxt.condition_flags[DRS_CF_N] = res8[7];
                    st_nxt.condition_flags[DRS_CF_Z] =
                        (res8 == 8'h00);
                    st_nxt.condition_flags[DRS_CF_V] =
                        (alu_op == DRS_OP_SUB)
                        ? (st_r.acc[7] != st_r.tmp[7])
                          && (res8[7] != st_r.acc[7])
                        : (st_r.acc[7] == st_r.tmp[7])
                          && (res8[7] != st_r.acc[7]);
                    st_nxt.condition_flags[DRS_CF_C] = sum9[8];
                end
            end
            DRS_OP_SHL: begin
                res8 = {st_r.acc[6:0], alu_shift_bit};
                st_nxt.acc[7:0] = res8;
                st_nxt.condition_flags[DRS_CF_C] = st_r.acc[7];
                st_nxt.condition_flags[DRS_CF_N] = res8[7];
                st_nxt.condition_flags[DRS_CF_Z] = (res8 == 8'h00);
            end
            DRS_OP_SHR: begin
                res8 = {alu_shift_bit, st_r.acc[7:1]};
                st_nxt.acc[7:0] = res8;
                st_nxt.condition_flags[DRS_CF_C] = st_r.acc[0];
                st_nxt.condition_flags[DRS_CF_N] = res8[7];
                st_nxt.condition_flags[DRS_CF_Z] = (res8 == 8'h00);
            end
            DRS_OP_LOG: begin
                st_nxt.acc[7:0] = alu_logic_res;
                st_nxt.condition_flags[DRS_CF_N] = alu_logic_res[7];
                st_nxt.condition_flags[DRS_CF_Z] =
                    (alu_logic_res == 8'h00);
            end
            default: begin
            end
        endcase
        // apb: one wait-free access, answered in the access phase
        st_nxt.ready = psel && !penable;
        st_nxt.err   = 1'b0;
        if (psel && !penable) begin
            st_nxt.rdata = 32'h0000_0000;
            if (paddr == DRS_OFF_PC) begin
                st_nxt.rdata[15:0] = st_r.pc;
            end else if (paddr == DRS_OFF_ACC) begin
                st_nxt.rdata[15:0] = st_r.acc;
            end else if (paddr == DRS_OFF_TMP) begin
                st_nxt.rdata[15:0] = st_r.tmp;
            end else if (paddr == DRS_OFF_IDX) begin
                st_nxt.rdata[15:0] = st_r.idx;
            end else if (paddr == DRS_OFF_EXP) begin
                st_nxt.rdata[15:0] = st_r.exp;
            end else if (paddr == DRS_OFF_STK) begin
                st_nxt.rdata[15:0] = st_r.stk;
            end else if (paddr == DRS_OFF_PSW) begin
                st_nxt.rdata[15:0] = {st_r.bank_pointer,
                                      st_r.condition_flags};
            end else if (paddr == DRS_OFF_IRQ) begin
                st_nxt.rdata[0] = st_r.accept;
            end else begin
                st_nxt.err = 1'b1;
            end
        end
        // apb write in access phase, takes priority over datapath
        if (wr_acc && st_r.ready) begin
            if (paddr == DRS_OFF_PC) begin
                st_nxt.pc = pwdata[15:0];
            end else if (paddr == DRS_OFF_ACC) begin
                st_nxt.acc = pwdata[15:0];
            end else if (paddr == DRS_OFF_TMP) begin
                st_nxt.tmp = pwdata[15:0];
            end else if (paddr == DRS_OFF_IDX) begin
                st_nxt.idx = pwdata[15:0];
            end else if (paddr == DRS_OFF_EXP) begin
                st_nxt.exp = pwdata[15:0];
            end else if (paddr == DRS_OFF_STK) begin
                st_nxt.stk = pwdata[15:0];
            end else if (paddr == DRS_OFF_PSW) begin
                st_nxt.bank_pointer    = pwdata[15:8];
                st_nxt.condition_flags = pwdata[7:0];
            end
        end
        if (!(psel && penable) || (rd_acc && st_r.ready)) begin
            st_nxt.ready = st_nxt.ready;
        end
        // interrupt: enabled and strictly higher priority than level
        st_nxt.accept = irq_req
            && st_r.condition_flags[DRS_CF_I]
            && (irq_level < {st_r.condition_flags[DRS_CF_IL1],
                             st_r.condition_flags[DRS_CF_IL0]});
        // general register address, bank wraps at supported count
        bank_sel = {{(16 - BW){1'b0}}, st_r.bank_pointer[BW-1:0]};
        st_nxt.gaddr = {DRS_GPR_PAGE, 8'h00}
                     | (bank_sel << 3)
                     | {13'h0000, gpr_num};
    end

    // empty hook to keep defaults in one place
    function automatic void st_st_defaults();
    endfunction : st_st_defaults

    // state register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.stk <= DRS_RST_STK;
            st_r.pc  <= DRS_RST_WORD;
            st_r.bank_pointer    <= DRS_RST_PSW[15:8];
            st_r.condition_flags <= DRS_RST_PSW[7:0];
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops
    assign program_counter     = st_r.pc;
    assign main_accumulator    = st_r.acc;
    assign temp_accumulator    = st_r.tmp;
    assign index_register      = st_r.idx;
    assign extra_pointer       = st_r.exp;
    assign stack_pointer       = st_r.stk;
    assign program_status_word = {st_r.bank_pointer, st_r.condition_flags};
    assign irq_accept          = st_r.accept;
    assign gpr_addr            = st_r.gaddr;
    assign prdata              = st_r.rdata;
    assign pready              = st_r.ready;
    assign pslverr             = st_r.err;

    // assertions
    ie_reset_a: assert property (@(posedge sys_clk)
        $fell(sys_rst) |-> !program_status_word[DRS_CF_I])
        else $error("interrupt enable not cleared by reset");
    irq_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        irq_accept |-> $past(st_r.condition_flags[DRS_CF_I]))
        else $error("interrupt accepted while disabled");
    irq_level_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        irq_accept |-> $past(irq_level)
            < $past(st_r.condition_flags[DRS_CF_IL1:DRS_CF_IL0]))
        else $error("interrupt accepted at too low a level");
    pc_inc_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pc_inc && !pc_load && !(psel && penable) |=>
            program_counter == $past(program_counter) + 16'h0001)
        else $error("program counter did not advance");
    zero_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        alu_op == DRS_OP_ADD && !alu_wide && !(psel && penable) |=>
            program_status_word[DRS_CF_Z]
            == (main_accumulator[7:0] == 8'h00))
        else $error("zero flag wrong after byte add");
    neg_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        alu_op == DRS_OP_SUB && !alu_wide && !(psel && penable) |=>
            program_status_word[DRS_CF_N] == main_accumulator[7])
        else $error("negative flag wrong after byte subtract");
    shift_carry_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        alu_op == DRS_OP_SHL && !(psel && penable) |=>
            program_status_word[DRS_CF_C] == $past(main_accumulator[7]))
        else $error("carry not shift-out");
    byte_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        alu_op == DRS_OP_ADD && !alu_wide && !acc_load
            && !(psel && penable) |=>
            main_accumulator[15:8] == $past(main_accumulator[15:8]))
        else $error("byte op changed accumulator high byte");
    half_carry_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        alu_op == DRS_OP_ADD && !(psel && penable) |=>
            program_status_word[DRS_CF_H] == ($past(main_accumulator[3:0])
            + $past(temp_accumulator[3:0]) > 5'd15))
        else $error("half carry wrong");
    gpr_addr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> gpr_addr[2:0] == $past(gpr_num))
        else $error("register number not in address");

    // apb handshake steps
    sequence apb_setup_s;
        psel && !penable;
    endsequence : apb_setup_s
    sequence apb_write_s;
        psel && penable && pwrite && pready;
    endsequence : apb_write_s

    ready_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        apb_setup_s |=> pready)
        else $error("no ready after setup");
    ready_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pready |=> !pready)
        else $error("ready held beyond access");
    slverr_map_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        apb_setup_s and (paddr > DRS_OFF_IRQ) |=> pslverr)
        else $error("unmapped access without error");
    write_land_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        apb_write_s and (paddr == DRS_OFF_STK) |=>
            stack_pointer == $past(pwdata[15:0]))
        else $error("stack pointer write lost");
    read_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    wide_carry_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        alu_op == DRS_OP_ADD && alu_wide && !(psel && penable) |=>
            program_status_word[DRS_CF_C]
            == (({1'b0, $past(main_accumulator)}
            + {1'b0, $past(temp_accumulator)}) > 17'h0FFFF))
        else $error("wide carry wrong");
    log_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        alu_op == DRS_OP_LOG && !(psel && penable) |=>
            program_status_word[1:0] == $past(program_status_word[1:0]))
        else $error("logic op changed carry or overflow");
    shr_carry_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        alu_op == DRS_OP_SHR && !(psel && penable) |=>
            program_status_word[DRS_CF_C] == $past(main_accumulator[0]))
        else $error("carry not shift-out on right shift");
    bank_addr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> gpr_addr[3 +: BW]
            == $past(program_status_word[8 +: BW]))
        else $error("bank pointer not in address");

endmodule : drs_core

// file: shared/drs_pkg.sv
// package of constants for the dedicated cpu register set
package drs_pkg;

    // apb byte offsets of the dedicated registers
    localparam logic [7:0] DRS_OFF_PC   = 8'h00;
    localparam logic [7:0] DRS_OFF_ACC  = 8'h04;
    localparam logic [7:0] DRS_OFF_TMP  = 8'h08;
    localparam logic [7:0] DRS_OFF_IDX  = 8'h0C;
    localparam logic [7:0] DRS_OFF_EXP  = 8'h10;
    localparam logic [7:0] DRS_OFF_STK  = 8'h14;
    localparam logic [7:0] DRS_OFF_PSW  = 8'h18;
    localparam logic [7:0] DRS_OFF_IRQ  = 8'h1C;

    // condition flag bit positions
    localparam int DRS_CF_H   = 7;
    localparam int DRS_CF_I   = 6;
    localparam int DRS_CF_IL1 = 5;
    localparam int DRS_CF_IL0 = 4;
    localparam int DRS_CF_N   = 3;
    localparam int DRS_CF_Z   = 2;
    localparam int DRS_CF_V   = 1;
    localparam int DRS_CF_C   = 0;

    // reset values
    localparam logic [15:0] DRS_RST_WORD = 16'h0000;
    localparam logic [15:0] DRS_RST_PSW  = 16'h0030;
    localparam logic [15:0] DRS_RST_STK  = 16'h0000;

    // general register base page, address bits 15:8
    localparam logic [7:0] DRS_GPR_PAGE = 8'h01;

    // alu operation codes
    typedef enum logic [2:0] {
        DRS_OP_NONE = 3'b000,
        DRS_OP_ADD  = 3'b001,
        DRS_OP_SUB  = 3'b010,
        DRS_OP_SHL  = 3'b011,
        DRS_OP_SHR  = 3'b100,
        DRS_OP_LOG  = 3'b101
    } drs_op_e;

endpackage : drs_pkg

// file: verification/drs_exec_model.sv
// execution unit model driving the register set datapath side
module drs_exec_model
    import drs_pkg::*;
(
    // clock
    input  wire logic        sys_clk,
    // load and increment strobes
    output logic             pc_load,
    output logic             pc_inc,
    output logic             acc_load,
    output logic             tmp_load,
    output logic             idx_load,
    output logic             exp_load,
    output logic             stk_load,
    output logic      [15:0] pc_value,
    output logic      [15:0] load_value,
    // alu request
    output logic      [2:0]  alu_op,
    output logic             alu_wide,
    output logic             alu_shift_bit,
    output logic      [7:0]  alu_logic_res,
    // interrupt request and register number
    output logic             irq_req,
    output logic      [1:0]  irq_level,
    output logic      [2:0]  gpr_num
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [6:0] lds;

    // one strobe line at a time, index 6 is the increment
    assign {pc_inc, stk_load, exp_load, idx_load, tmp_load, acc_load,
            pc_load} = lds;

    // idle datapath from time zero
    initial begin
        lds           = '0;
        pc_value      = '0;
        load_value    = '0;
        alu_op        = DRS_OP_NONE;
        alu_wide      = 1'b0;
        alu_shift_bit = 1'b0;
        alu_logic_res = '0;
        irq_req       = 1'b0;
        irq_level     = '0;
        gpr_num       = '0;
    end

    // single-cycle strobe, returns once the result is settled
    task automatic load(input int sel, input logic [15:0] v);
        @(posedge sys_clk);
        lds        <= 7'(1 << sel);
        pc_value   <= v;
        load_value <= v;
        @(posedge sys_clk);
        lds <= '0;
        #1;
    endtask : load

    // single-cycle alu operation on accumulator and temporary
    task automatic alu(input drs_op_e op, input logic w);
        @(posedge sys_clk);
        alu_op   <= op;
        alu_wide <= w;
        @(posedge sys_clk);
        alu_op <= DRS_OP_NONE;
        #1;
    endtask : alu

    // held levels, sampled by the registered outputs one edge later
    task automatic hold(input logic r, input logic [1:0] l,
                        input logic [2:0] n);
        @(posedge sys_clk);
        irq_req   <= r;
        irq_level <= l;
        gpr_num   <= n;
        @(posedge sys_clk);
        #1;
    endtask : hold
endmodule : drs_exec_model

// file: verification/test_cpu_dedicated_register_set.sv
// self-checking bench for the dedicated cpu register set
module test_cpu_dedicated_register_set
    import drs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic             sys_clk, sys_rst, psel, penable, pwrite;
    logic             pready, pslverr, irq_accept, alu_wide, alu_shift_bit;
    logic             pc_load, pc_inc, acc_load, tmp_load, idx_load;
    logic             exp_load, stk_load, irq_req;
    logic [1:0]       irq_level;
    logic [2:0]       alu_op, gpr_num;
    logic [7:0]       paddr, alu_logic_res;
    logic [31:0]      pwdata, prdata;
    logic [15:0]      pc_value, load_value, gpr_addr, program_status_word;
    logic [15:0]      program_counter, main_accumulator, temp_accumulator;
    logic [15:0]      index_register, extra_pointer, stack_pointer;
    logic [5:0][15:0] regs;
    int               bad_count = 0;
    int               samples_checked = 0;
    int               cycles = 0;
    localparam logic [7:0] offs [6] = '{DRS_OFF_PC, DRS_OFF_ACC,
        DRS_OFF_TMP, DRS_OFF_IDX, DRS_OFF_EXP, DRS_OFF_STK};

    assign regs = {stack_pointer, extra_pointer, index_register,
                   temp_accumulator, main_accumulator, program_counter};

    drs_core #(.BANKS(32)) drs_core_inst (.sys_clk, .sys_rst, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pc_load, .pc_inc, .pc_value, .acc_load, .tmp_load, .idx_load,
        .exp_load, .stk_load, .load_value, .alu_op, .alu_wide,
        .alu_shift_bit, .alu_logic_res, .irq_req, .irq_level, .gpr_num,
        .program_counter, .main_accumulator, .temp_accumulator,
        .index_register, .extra_pointer, .stack_pointer,
        .program_status_word, .irq_accept, .gpr_addr);

    drs_exec_model drs_exec_model_inst (.sys_clk, .pc_load, .pc_inc,
        .acc_load, .tmp_load, .idx_load, .exp_load, .stk_load, .pc_value,
        .load_value, .alu_op, .alu_wide, .alu_shift_bit, .alu_logic_res,
        .irq_req, .irq_level, .gpr_num);

    // free-running clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check

    // apb transfer held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // look once the registered answer has settled, before the next edge
        #1;
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
            #1;
        end
        // answer stands until the edge that completes the access
        r = prdata;
        e = pslverr;
        @(posedge sys_clk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, '0, r, e);
        check(r, x);
        check(32'(e), 32'(xe));
    endtask : rd

    task automatic t_reset();
        rd(DRS_OFF_PSW, 32'(DRS_RST_PSW), 1'b0);
        check(32'(program_status_word[DRS_CF_I]), 32'h0);
        rd(DRS_OFF_PC, 32'h0, 1'b0);
        wr(8'h20, 32'h0000_5A5A);
        rd(8'h20, 32'h0, 1'b1);
        $display("reset test done");
    endtask : t_reset

    task automatic t_regs();
        for (int i = 0; i < 6; i++) begin
            wr(offs[i], 32'hFFFF_1350 + 32'(i));
            rd(offs[i], 32'h0000_1350 + 32'(i), 1'b0);
            drs_exec_model_inst.load(i, 16'hA0C0 + 16'(i));
            check(32'(regs[i]), 32'hA0C0 + 32'(i));
        end
        drs_exec_model_inst.load(6, 16'h0000);
        check(32'(program_counter), 32'hA0C1);
        $display("register test done");
    endtask : t_regs

    // flag order in f and m: h n z v c
    task automatic t_alu(input logic [15:0] a, t, input drs_op_e op,
                         input logic w, input logic [15:0] x,
                         input logic [4:0] f, m);
        drs_exec_model_inst.load(1, a);
        drs_exec_model_inst.load(2, t);
        drs_exec_model_inst.alu(op, w);
        check(32'(w ? main_accumulator : main_accumulator[7:0]), 32'(x));
        check(32'({program_status_word[7], program_status_word[3:0]} & m),
              32'(f & m));
    endtask : t_alu

    task automatic t_irq();
        drs_exec_model_inst.hold(1'b1, 2'd0, 3'd0);
        check(32'(irq_accept), 32'h0);
        wr(DRS_OFF_PSW, 32'h0000_0060);
        drs_exec_model_inst.hold(1'b1, 2'd1, 3'd0);
        check(32'(irq_accept), 32'h1);
        rd(DRS_OFF_IRQ, 32'h1, 1'b0);
        drs_exec_model_inst.hold(1'b1, 2'd2, 3'd0);
        check(32'(irq_accept), 32'h0);
        wr(DRS_OFF_PSW, 32'h0000_0070);
        drs_exec_model_inst.hold(1'b1, 2'd2, 3'd0);
        check(32'(irq_accept), 32'h1);
        drs_exec_model_inst.hold(1'b1, 2'd3, 3'd0);
        check(32'(irq_accept), 32'h0);
        $display("interrupt test done");
    endtask : t_irq

    task automatic t_gpr();
        wr(DRS_OFF_PSW, 32'h0000_0500);
        drs_exec_model_inst.hold(1'b0, 2'd0, 3'd3);
        check(32'(program_status_word[15:8]), 32'h05);
        check(32'(gpr_addr), 32'({DRS_GPR_PAGE, 5'd5, 3'd3}));
        wr(DRS_OFF_PSW, 32'h0000_1F00);
        drs_exec_model_inst.hold(1'b0, 2'd0, 3'd7);
        check(32'(gpr_addr), 32'({DRS_GPR_PAGE, 5'd31, 3'd7}));
        $display("bank test done");
    endtask : t_gpr

    // main sequence
    initial begin
        sys_rst = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_regs();
        t_alu(16'h08, 16'h08, DRS_OP_ADD, 0, 16'h10, 5'h10, 5'h1F);
        t_alu(16'h7F, 16'h01, DRS_OP_ADD, 0, 16'h80, 5'h1A, 5'h1F);
        t_alu(16'hFF, 16'h01, DRS_OP_ADD, 0, 16'h00, 5'h15, 5'h1F);
        t_alu(16'h00, 16'h01, DRS_OP_SUB, 0, 16'hFF, 5'h19, 5'h1F);
        t_alu(16'h80, 16'h01, DRS_OP_SUB, 0, 16'h7F, 5'h12, 5'h1F);
        t_alu(16'h81, 16'h00, DRS_OP_SHL, 0, 16'h02, 5'h01, 5'h0D);
        t_alu(16'h01, 16'h00, DRS_OP_SHR, 0, 16'h00, 5'h05, 5'h0D);
        t_alu(16'h81, 16'h00, DRS_OP_LOG, 0, 16'h00, 5'h04, 5'h0C);
        t_alu(16'hFFFF, 16'h1, DRS_OP_ADD, 1, 16'h0, 5'h05, 5'h0D);
        $display("alu test done");
        t_irq();
        t_gpr();
        stop_test();
    end
endmodule : test_cpu_dedicated_register_set
